// ### rtl/dcps_pkg.sv
package dcps_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_GAIN = 8'h04;
    localparam logic [7:0] ADDR_OFFS = 8'h08;
    localparam logic [7:0] ADDR_CFG = 8'h0C;
    localparam logic [7:0] ADDR_SAFE = 8'h10;
    localparam logic [7:0] ADDR_FAULT = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFG_RAMP_EN = 0;
    localparam int CFG_PROFILE = 1;
    localparam int CFG_STEP_LSB = 2;
    localparam int CFG_RATE_LSB = 5;
    localparam int CFG_FORCE = 8;
    localparam int CFG_BRK = 9;
    localparam int CFG_W = 10;
    localparam int FAULT_SAFE = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_SAFE = 1;
    localparam int ST_CODE_LSB = 16;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [15:0] GAIN_RST = 16'h8000;
    localparam logic [15:0] OFFS_RST = 16'h0000;
    localparam logic [15:0] SAFE_RST = 16'h0000;
    localparam logic [CFG_W-1:0] CFG_RST = 10'h000;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 250_000_000;
    localparam int INT_CLK_HZ = 1_228_800;
    localparam int INT_DIV = CLK_HZ / INT_CLK_HZ;
    localparam logic [7:0] DIV_LAST = 8'(INT_DIV - 1);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {RAMP_IDLE, RAMP_RUN} dcps_ramp_t;
endpackage : dcps_pkg

// ### rtl/dcps_cal.sv
`timescale 1ns/1ps
`default_nettype none
module dcps_cal
    import dcps_pkg::*;
#(
    parameter int RES = 16
) (
    input wire logic [15:0] data,
    input wire logic [15:0] gain,
    input wire logic [15:0] offs,
    output logic [15:0] code
);
    localparam logic [15:0] MASK = (RES == 14) ? 16'hFFFC : 16'hFFFF;

    logic [32:0] prod;
    logic signed [18:0] sum;

    always_comb begin
        // Gain is one half plus field over full scale; product is truncated
        prod = 33'(data & MASK) * (33'h0_8000 + 33'(gain & MASK));  // [R1] [R2] [R4]
        sum = $signed({2'b00, prod[32:16]}) + $signed({{3{offs[15]}}, offs & MASK});  // [R3] [R4]
        // Clamp instead of wrapping on calibration overflow
        if (sum < 0) begin  // [R20]
            code = 16'h0000;
        end else if (sum > $signed(19'h0FFFF)) begin
            code = MASK;
        end else begin
            code = sum[15:0] & MASK;
        end
    end
endmodule : dcps_cal
`default_nettype wire

// ### rtl/dcps_ramp_step.sv
`timescale 1ns/1ps
`default_nettype none
module dcps_ramp_step
    import dcps_pkg::*;
#(
    parameter int RES = 16
) (
    input wire logic [15:0] cur,
    input wire logic [15:0] tgt,
    input wire logic [15:0] origin,
    input wire logic [2:0] step_sel,
    input wire logic profile,
    output logic [15:0] nxt
);
    logic up;
    logic [15:0] remain;
    logic [15:0] trav;
    logic [18:0] base;
    logic [18:0] stride;

    always_comb begin
        up = tgt > cur;
        remain = up ? tgt - cur : cur - tgt;
        trav = (cur >= origin) ? cur - origin : origin - cur;
        base = 19'h00001 << (19'(step_sel) + 19'(16 - RES));  // [R7]
        stride = base;
        // Sine profile: fine steps near both ends, coarse in the middle
        if (profile && (19'(trav) >= (base << 3)) && (19'(remain) > (base << 3))) begin  // [R10]
            stride = base << 2;
        end
        if (19'(remain) <= stride) begin
            nxt = tgt;
        end else if (up) begin
            nxt = cur + stride[15:0];
        end else begin
            nxt = cur - stride[15:0];
        end
    end
endmodule : dcps_ramp_step
`default_nettype wire

// ### rtl/dcps_code_path.sv
// Behaviour
// R1: Fields left-justified; 14-bit ignores two LSBs
// R2: Gain factor is half plus field/2^N
// R3: Offset is two's complement, signed top bit
// R4: Code = data times gain plus offset, truncated
// R5: Calibration takes effect on next data write
// R6: Ramping off at reset; off means direct
// R7: Step size and update rate fields steer ramp
// R8: Ramp moves one step per rate update
// R9: New target ramps from current applied code
// R10: Linear or sinusoidal profile by select bit
// R11: Disabling ramp mid-way applies target at once
// R12: Safe state drives safe code, data kept
// R13: Safe switch synchronous; ramps when enabled
// R14: New code applied within internal clock latency
// R15: Calibration change while ramping pulses busy event
// R16: Force bit enters safe state
// R17: Alarm enters safe state when response enabled
// R18: Break mode: serial pin high forces safe
// R19: Host spaces data updates by 2.1 us
// R20: Calibrated code saturates, never wraps
// R21: Leaving safe returns to calibrated code
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module dcps_code_path
    import dcps_pkg::*;
#(
    parameter int RES = 16,
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic alarm_in,
    input wire logic serial_in_pin,
    output logic [15:0] dac_code,
    output logic ramp_in_progress,
    output logic safe_state_active,
    output logic calib_change_pulse
);
    localparam int APPLY_MAX = INT_DIV + 3;

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [15:0] data_q;
    logic [15:0] gain_q;
    logic [15:0] offs_q;
    logic [15:0] safe_code_reg_q;
    logic [CFG_W-1:0] cfg_q;
    logic fault_q;
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic data_load_q;
    logic [15:0] cal_tgt_q;
    logic [7:0] div_q;
    logic tick_q;
    logic [6:0] rate_cnt_q;
    logic safe_q;
    logic [15:0] last_tgt_q;
    logic [15:0] origin_q;
    logic [15:0] applied_q;
    dcps_ramp_t st_q;
    logic busy_q;
    logic pulse_q;

    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic ar_take;
    logic aw_held_d;
    logic w_held_d;
    logic rvalid_d;
    logic [31:0] wr_word;
    logic [15:0] cal_code;
    logic [15:0] sel_tgt;
    logic [15:0] ramp_nxt;
    logic [6:0] rate_mask;
    logic ramp_tick;
    logic ramp_en;
    logic safe_req;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic reg_known(input logic [7:0] a);
        return (a == ADDR_DATA) || (a == ADDR_GAIN) || (a == ADDR_OFFS) || (a == ADDR_CFG)
            || (a == ADDR_SAFE) || (a == ADDR_FAULT) || (a == ADDR_STATUS);
    endfunction : reg_known

    function automatic logic [31:0] rd_word(input logic [7:0] a);
        case (a)
            ADDR_DATA: rd_word = {16'h0000, data_q};
            ADDR_GAIN: rd_word = {16'h0000, gain_q};
            ADDR_OFFS: rd_word = {16'h0000, offs_q};
            ADDR_CFG: rd_word = {22'h000000, cfg_q};
            ADDR_SAFE: rd_word = {16'h0000, safe_code_reg_q};
            ADDR_FAULT: rd_word = {31'h00000000, fault_q};
            ADDR_STATUS: rd_word = {applied_q, 14'h0000, safe_q, busy_q};
            default: rd_word = 32'h00000000;
        endcase
    endfunction : rd_word

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : wmerge

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    always_comb begin
        aw_take = awvalid && awready_q;
        w_take = wvalid && wready_q;
        wr_fire = aw_held_q && w_held_q && !bvalid_q;
        aw_held_d = aw_take ? 1'b1 : (wr_fire ? 1'b0 : aw_held_q);
        w_held_d = w_take ? 1'b1 : (wr_fire ? 1'b0 : w_held_q);
        wr_word = wmerge(rd_word(awaddr_q), wdata_q, wstrb_q);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awready_q <= !aw_held_d;
            wready_q <= !w_held_d;
            if (aw_take) begin
                awaddr_q <= 8'(awaddr);
            end
            if (w_take) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= reg_known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    always_comb begin
        ar_take = arvalid && arready_q;
        rvalid_d = ar_take ? 1'b1 : ((rvalid_q && rready) ? 1'b0 : rvalid_q);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            arready_q <= !rvalid_d;
            if (ar_take) begin
                rdata_q <= rd_word(8'(araddr));
                rresp_q <= reg_known(8'(araddr)) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= DATA_RST;
            gain_q <= GAIN_RST;
            offs_q <= OFFS_RST;
            safe_code_reg_q <= SAFE_RST;
            cfg_q <= CFG_RST;  // [R6]
            fault_q <= 1'b0;
        end else if (wr_fire) begin
            case (awaddr_q)
                ADDR_DATA: data_q <= wr_word[15:0];
                ADDR_GAIN: gain_q <= wr_word[15:0];
                ADDR_OFFS: offs_q <= wr_word[15:0];
                ADDR_CFG: cfg_q <= wr_word[CFG_W-1:0];
                ADDR_SAFE: safe_code_reg_q <= wr_word[15:0];
                ADDR_FAULT: fault_q <= wr_word[FAULT_SAFE];
                default: ;
            endcase
        end
    end

    // Busy event when calibration moves under an enabled ramp
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_q <= 1'b0;
            data_load_q <= 1'b0;
        end else begin
            pulse_q <= wr_fire && ramp_en && ((awaddr_q == ADDR_GAIN) || (awaddr_q == ADDR_OFFS));  // [R15]
            data_load_q <= wr_fire && (awaddr_q == ADDR_DATA);
        end
    end

    // ------------------------------------------------------------
    // Calibration; target latched only on a data write
    // ------------------------------------------------------------
    dcps_cal #(.RES(RES)) u_cal (
        .data(data_q),
        .gain(gain_q),
        .offs(offs_q),
        .code(cal_code)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_tgt_q <= 16'h0000;
        end else if (data_load_q) begin
            cal_tgt_q <= cal_code;  // [R5]
        end
    end

    // ------------------------------------------------------------
    // Internal converter clock and safe-state request
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 8'h00;
            tick_q <= 1'b0;
            rate_cnt_q <= 7'h00;
        end else begin
            tick_q <= (div_q == DIV_LAST);  // [R14]
            div_q <= (div_q == DIV_LAST) ? 8'h00 : div_q + 8'h01;
            if (tick_q) begin
                rate_cnt_q <= rate_cnt_q + 7'h01;
            end
        end
    end

    always_comb begin
        ramp_en = cfg_q[CFG_RAMP_EN];
        safe_req = cfg_q[CFG_FORCE]  // [R16]
            || (alarm_in && fault_q)  // [R17]
            || (cfg_q[CFG_BRK] && serial_in_pin);  // [R18]
        sel_tgt = safe_q ? safe_code_reg_q : cal_tgt_q;  // [R12] [R21]
        // Update rate divides the internal clock by a power of two
        rate_mask = 7'((8'h01 << cfg_q[CFG_RATE_LSB +: 3]) - 8'h01);  // [R7]
        ramp_tick = tick_q && ((rate_cnt_q & rate_mask) == 7'h00);  // [R8]
    end

    // Sampled on the internal clock so the switch never lands mid-update
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            safe_q <= 1'b0;
        end else if (tick_q) begin
            safe_q <= safe_req;  // [R13]
        end
    end

    // ------------------------------------------------------------
    // Ramp engine
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_tgt_q <= 16'h0000;
            origin_q <= 16'h0000;
        end else if (sel_tgt != last_tgt_q) begin
            last_tgt_q <= sel_tgt;
            origin_q <= applied_q;  // [R9]
        end
    end

    dcps_ramp_step #(.RES(RES)) u_step (
        .cur(applied_q),
        .tgt(sel_tgt),
        .origin(origin_q),
        .step_sel(cfg_q[CFG_STEP_LSB +: 3]),
        .profile(cfg_q[CFG_PROFILE]),
        .nxt(ramp_nxt)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            applied_q <= 16'h0000;
            st_q <= RAMP_IDLE;
            busy_q <= 1'b0;
        end else begin
            case (st_q)
                RAMP_IDLE: begin
                    if (!ramp_en) begin
                        if (tick_q) begin
                            applied_q <= sel_tgt;  // [R6] [R14]
                        end
                    end else if (tick_q && (applied_q != sel_tgt)) begin
                        st_q <= RAMP_RUN;  // [R13] [R21]
                        busy_q <= 1'b1;
                    end
                end
                RAMP_RUN: begin
                    if (!ramp_en) begin
                        applied_q <= sel_tgt;  // [R11]
                        st_q <= RAMP_IDLE;
                        busy_q <= 1'b0;
                    end else if (ramp_tick) begin
                        applied_q <= ramp_nxt;  // [R8] [R9]
                        if (ramp_nxt == sel_tgt) begin
                            st_q <= RAMP_IDLE;
                            busy_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    st_q <= RAMP_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign dac_code = applied_q;
    assign ramp_in_progress = busy_q;
    assign safe_state_active = safe_q;
    assign calib_change_pulse = pulse_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking dcps_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_abort_apply: assert property (  // [R11]
        busy_q && !ramp_en |=> (applied_q == $past(sel_tgt)) && !busy_q)
        else $error("ramp abort did not apply target");
    chk_direct_apply: assert property (  // [R6]
        (st_q == RAMP_IDLE) && !ramp_en && tick_q |=> dac_code == $past(sel_tgt))
        else $error("direct code not applied on tick");
    chk_busy_pulse: assert property (  // [R15]
        wr_fire && ramp_en && (awaddr_q == ADDR_GAIN) |=> calib_change_pulse ##1 !calib_change_pulse)
        else $error("missing single calibration pulse");
    chk_target_load: assert property (  // [R5]
        data_load_q |=> cal_tgt_q == $past(cal_code))
        else $error("target not loaded on data write");
    chk_target_hold: assert property (  // [R5]
        !data_load_q |=> $stable(cal_tgt_q))
        else $error("target moved without data write");
    chk_step_timing: assert property (  // [R8]
        busy_q && ramp_en && !ramp_tick |=> $stable(dac_code))
        else $error("ramp moved off an update tick");
    chk_data_kept: assert property (  // [R12]
        safe_q && !(wr_fire && (awaddr_q == ADDR_DATA)) |=> $stable(data_q))
        else $error("data register changed in safe state");
    chk_brk_gate: assert property (  // [R18]
        tick_q && !cfg_q[CFG_BRK] && !cfg_q[CFG_FORCE] && !(alarm_in && fault_q) |=> !safe_q)
        else $error("safe state without a cause");
    chk_apply_latency: assert property (  // [R14]
        data_load_q && !ramp_en ##1 !safe_q && !ramp_en [*2]
        |-> ##[1:APPLY_MAX] (dac_code == cal_tgt_q || safe_q || ramp_en))
        else $error("data code not applied in time");

    cov_ramp_done: cover property (busy_q ##1 !busy_q && ramp_en);
    cov_safe_enter: cover property (!safe_q ##1 safe_q);
    cov_abort: cover property (busy_q && !ramp_en);
endmodule : dcps_code_path
`default_nettype wire

// ### test/dcps_host.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Register bus master standing in for the host controller
// ------------------------------------------------------------
module dcps_host (
    input wire logic aclk,
    output logic awvalid,
    input wire logic awready,
    output logic [7:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    output logic arvalid,
    input wire logic arready,
    output logic [7:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    logic hung = 1'h0;
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic aw_d;
        logic w_d;
        {aw_d, w_d} = 2'h0;
        r = 2'h3;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        {awvalid, wvalid, bready} <= 3'h7;
        for (n = 0; n < 1000; n++) begin
            @(posedge aclk);
            if (!aw_d && awready) begin
                aw_d = 1'h1;
                awvalid <= 1'h0;
                awaddr <= ~a;
            end
            if (!w_d && wready) begin
                w_d = 1'h1;
                wvalid <= 1'h0;
                wdata <= ~d;
            end
            if (bvalid) begin
                r = bresp;
                bready <= 1'h0;
                break;
            end
        end
        @(posedge aclk);
        if (n == 1000) hung = 1'h1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ar_d;
        ar_d = 1'h0;
        {d, r} = 34'h3;
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (n = 0; n < 1000; n++) begin
            @(posedge aclk);
            if (!ar_d && arready) begin
                ar_d = 1'h1;
                arvalid <= 1'h0;
                araddr <= ~a;
            end
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'h0;
                break;
            end
        end
        @(posedge aclk);
        if (n == 1000) hung = 1'h1;
    endtask : rd
endmodule : dcps_host
`default_nettype wire

// ### test/dac_code_path_slew_clear_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dac_code_path_slew_clear_bench
    import dcps_pkg::*;
;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic alarm_in = 1'h0;
    logic serial_in_pin = 1'h0;
    logic [15:0] dac_code;
    logic ramp_in_progress, safe_state_active, calib_change_pulse;
    int n_pulse = 0;
    int n_errors = 0;
    int comparisons = 0;
    always #2 aclk = ~aclk;
    always @(posedge aclk) if (calib_change_pulse === 1'h1) n_pulse <= n_pulse + 1;
    dcps_code_path u_dcps_code_path (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .alarm_in(alarm_in),
        .serial_in_pin(serial_in_pin), .dac_code(dac_code), .ramp_in_progress(ramp_in_progress),
        .safe_state_active(safe_state_active), .calib_change_pulse(calib_change_pulse));
    dcps_host u_dcps_host (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        logic [1:0] r;
        u_dcps_host.wr(a, d, r);
        chk("bresp", {30'h0, er}, {30'h0, r});
        if (u_dcps_host.hung) results();
    endtask : wreg
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        logic [31:0] d;
        logic [1:0] r;
        u_dcps_host.rd(a, d, r);
        chk("rdata", e, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
        if (u_dcps_host.hung) results();
    endtask : rchk
    task automatic wdat(input logic [15:0] d);
        repeat (525) @(posedge aclk);
        wreg(ADDR_DATA, {16'h0, d});
    endtask : wdat
    task automatic wcode(input logic [15:0] e, input int lim);
        int n;
        for (n = 0; n < lim && dac_code !== e; n++) @(posedge aclk);
        chk("dac_code", {16'h0, e}, {16'h0, dac_code});
        if (dac_code !== e) results();
    endtask : wcode
    task automatic first_step(input logic [15:0] d);
        logic [15:0] c;
        int n;
        c = dac_code;
        for (n = 0; n < 1000 && dac_code === c; n++) @(posedge aclk);
        chk("ramp step", {16'h0, d}, {16'h0, 16'(dac_code - c)});
        chk("ramp busy", 32'h1, {31'h0, ramp_in_progress});
        if (n == 1000) results();
    endtask : first_step
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        chk("reset code", 32'h0, {15'h0, ramp_in_progress, dac_code});
        rchk(ADDR_GAIN, 32'h8000);
        rchk(ADDR_CFG, 32'h0);
        rchk(ADDR_SAFE, 32'h0);
        rchk(8'h1C, 32'h0, RESP_SLVERR);
        wreg(8'h1C, 32'h5A5A, RESP_SLVERR);
        $display("test regs done");
    endtask : t_regs
    task automatic t_cal;
        wdat(16'h1000);
        wcode(16'h1000, 210);
        wreg(ADDR_GAIN, 32'h0);
        wreg(ADDR_OFFS, 32'hFFFC);
        repeat (400) @(posedge aclk);
        chk("held code", 32'h1000, {16'h0, dac_code});
        wdat(16'h8001);
        wcode(16'h3FFC, 210);
        wreg(ADDR_GAIN, 32'hFFFF);
        wreg(ADDR_OFFS, 32'h7FFF);
        wdat(16'hFFFF);
        wcode(16'hFFFF, 210);
        wreg(ADDR_GAIN, 32'h0);
        wreg(ADDR_OFFS, 32'h8000);
        wdat(16'h0004);
        wcode(16'h0000, 210);
        wreg(ADDR_GAIN, 32'h8000);
        wreg(ADDR_OFFS, 32'h0);
        wdat(16'h2000);
        wcode(16'h2000, 210);
        $display("test cal done");
    endtask : t_cal
    task automatic t_safe;
        wreg(ADDR_SAFE, 32'h1234);
        wreg(ADDR_CFG, 32'h100);
        wcode(16'h1234, 420);
        chk("safe flag", 32'h1, {31'h0, safe_state_active});
        rchk(ADDR_DATA, 32'h2000);
        wreg(ADDR_CFG, 32'h0);
        wcode(16'h2000, 420);
        wreg(ADDR_FAULT, 32'h1);
        alarm_in <= 1'h1;
        wcode(16'h1234, 420);
        alarm_in <= 1'h0;
        wcode(16'h2000, 420);
        serial_in_pin <= 1'h1;
        repeat (400) @(posedge aclk);
        chk("pin ignored", 32'h2000, {16'h0, dac_code});
        wreg(ADDR_CFG, 32'h200);
        wcode(16'h1234, 420);
        serial_in_pin <= 1'h0;
        wcode(16'h2000, 420);
        wreg(ADDR_CFG, 32'h0);
        $display("test safe done");
    endtask : t_safe
    task automatic t_ramp;
        int c;
        wreg(ADDR_CFG, 32'h1D);
        c = n_pulse;
        wreg(ADDR_GAIN, 32'h8000);
        @(posedge aclk);
        chk("calib pulse", 32'h1, 32'(n_pulse - c));
        wdat(16'h3000);
        first_step(16'h0080);
        wcode(16'h3000, 20000);
        wreg(ADDR_CFG, 32'h11D);
        first_step(16'hFF80);
        wcode(16'h1234, 20000);
        wreg(ADDR_CFG, 32'h1D);
        first_step(16'h0080);
        wreg(ADDR_CFG, 32'h0);
        wcode(16'h3000, 8);
        wreg(ADDR_CFG, 32'h1F);
        wdat(16'h1000);
        repeat (8) first_step(16'hFF80);
        first_step(16'hFE00);
        wcode(16'h1000, 20000);
        wreg(ADDR_CFG, 32'h0);
        $display("test ramp done");
    endtask : t_ramp
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_cal();
        t_safe();
        t_ramp();
        results();
    end
endmodule : dac_code_path_slew_clear_bench
`default_nettype wire
